// ==== inc/flbl_defs.vh ====
// Purpose: Constants for the flash block lock and control-bit logic.
// Assumes: One clock at 100 MHz, synchronous active-high reset.
// Notes: Offsets are byte addresses on the plain register port.
//
// Operation
// [R1] Low sectorization code decodes to sector layout; codes 011 to 101 reserved.
// [R2] Several command bits written together: only the lowest level bit applies.
// [R3] Stall/abort mode: stall fetch, set or clear good flag, pulse event.
// [R4] Software using stall/abort mode ignores the read-while-write error flag.
// [R5] Software clears the read-while-write error flag after each operation.
// [R6] A block is protected when primary or secondary lock bit is one.
// [R7] During flash reset the nonvolatile lock image loads into lock register; the code loads it on the first edge after reset ends.
// [R8] Only image bits 31:0 give lock values; bits 63:32 ignored.
// [R9] Password write sets read-only lock enable until next reset.
// [R10] Lock bit writes ignored unless lock enable is set.
// [R11] Lock writes blocked from interlock write until done, and while suspended; the code blocks only once EHV clears done, and in erase suspend.
// [R12] Program and erase pulses refused to locked blocks, accepted otherwise.
// [R13] Each reset returns lock bits to the nonvolatile image value.
// [R14] Absent blocks hold lock bits at one; writes to them do nothing.
// [R15] Mid bits map to sectors 7 and 6; low bits 5 to 0 map directly.
// [R16] Factory image is all ones, locking everything; software may reprogram.
// [R17] Software never erases the test block; only shadow may be erased.
// [R18] Done flag sets when a high-voltage sequence ends, releasing lock blocking.
// [R19] Read-while-write error clears only on a write of one.
// [R20] Non-password write while enable is clear changes nothing.
// [R21] With enable set, only writable lock bits take the written value.
`ifndef FLBL_DEFS_VH
`define FLBL_DEFS_VH

`define FLBL_AW 8
`define FLBL_CTRL_OFS 8'h00
`define FLBL_LOCK_OFS 8'h04
`define FLBL_SECT_OFS 8'h08

`define FLBL_EHV 0
`define FLBL_ERASE_SUSPEND 1
`define FLBL_ERS 2
`define FLBL_PSUS 3
`define FLBL_PGM 4
`define FLBL_PEG 9
`define FLBL_DONE 10
`define FLBL_RWE 15
`define FLBL_SAWW_EN 16
`define FLBL_SAWW_ABORT 17
`define FLBL_EVT_EN 18

`define FLBL_LME 31
`define FLBL_TEST_SHADOW_LOCK 20
`define FLBL_MLK_LO 16
`define FLBL_PASSWORD 32'ha1a11111
`define FLBL_LOW_PRESENT 16'h003f
`define FLBL_MID_PRESENT 2'h3

`define FLBL_LAS_NONE 3'h0
`define FLBL_LAS_2X128 3'h1
`define FLBL_LAS_MIX6 3'h2
`define FLBL_LAS_4X16 3'h6
`define FLBL_LAS_MIX8 3'h7

`endif

// ==== rtl/flbl_ctrl.v ====
// Purpose: Lock register, command-bit arbitration and protection for flash.
// Assumes: Array-side inputs come from logic on the same clock.
// Notes: Secondary locks arrive as inputs; their register lives elsewhere.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "flbl_defs.vh"

module flbl_ctrl #(
   parameter [2:0] LOW_SECT = 3'h7,
   parameter MID_SECT = 1'b0,
   parameter [15:0] LOW_PRESENT = `FLBL_LOW_PRESENT,
   parameter [1:0] MID_PRESENT = `FLBL_MID_PRESENT
) (
   input wire clock,
   input wire sys_rst,
   input wire [`FLBL_AW-1:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [31:0] reg_rdata,
   input wire [63:0] nonvolatile_lock_image,
   input wire [15:0] secondary_low_lock,
   input wire [1:0] secondary_mid_lock,
   input wire secondary_test_shadow_lock,
   input wire interlock_write,
   input wire hv_seq_end,
   input wire hv_seq_fail,
   input wire fetch_during_write,
   input wire pulse_req,
   input wire [4:0] pulse_block,
   output wire pulse_grant,
   output wire pulse_refused,
   output wire [15:0] low_protect,
   output wire [1:0] mid_protect,
   output wire test_shadow_protect,
   output wire cpu_stall,
   output reg saww_event,
   output wire [3:0] low_sector_count,
   output wire low_sect_reserved,
   output wire mid_sect_reserved,
   output wire erase_select,
   output wire program_select,
   output wire high_voltage_enable,
   output wire erase_suspend,
   output wire lock_busy
);

   reg erase_sel;
   reg program_sel;
   reg hv_enable;
   reg erase_susp;
   reg prog_susp;
   reg op_done;
   reg operation_good_flag;
   reg read_while_write_error;
   reg saww_enable;
   reg saww_abort;
   reg event_enable;
   reg lock_write_enable;
   reg test_shadow_lock;
   reg [1:0] mid_space_lock;
   reg [15:0] low_space_lock;
   reg image_load;
   reg interlock_seen;

   reg next_erase_sel;
   reg next_program_sel;
   reg next_hv_enable;
   reg next_erase_susp;
   reg next_op_done;
   reg next_peg;
   reg next_rwe;
   reg next_saww_event;
   reg [3:0] chg;
   reg abort_now;
   reg [3:0] low_count;

   wire ctrl_wr;
   wire lock_wr;
   wire password_hit;
   wire lock_bits_wr;
   wire suspended;
   wire [31:0] image_low;
   wire [31:0] ctrl_value;
   wire [31:0] lock_value;
   wire [31:0] sect_value;
   wire fetch_hit;
   wire block_locked;

   assign ctrl_wr = reg_write && (reg_addr == `FLBL_CTRL_OFS);
   assign lock_wr = reg_write && (reg_addr == `FLBL_LOCK_OFS);

   // Upper half of the image may hold check bits, so it is never looked at.
   assign image_low = nonvolatile_lock_image[31:0]; // [R8]

   assign password_hit = lock_wr && (reg_wdata == `FLBL_PASSWORD); // [R9]

   // A suspended operation keeps its target sectors, so locks stay frozen.
   assign suspended = erase_susp && op_done; // [R11]
   assign lock_busy = (interlock_seen && !op_done) || suspended; // [R11]
   // A non-password write with the enable clear falls through untouched.
   assign lock_bits_wr = lock_wr && lock_write_enable && !lock_busy; // [R10] [R20]

   assign low_protect = low_space_lock | secondary_low_lock; // [R6]
   assign mid_protect = mid_space_lock | secondary_mid_lock; // [R6]
   assign test_shadow_protect = test_shadow_lock |
                                secondary_test_shadow_lock; // [R6]

   // Block index: 0 to 15 low sectors, 16 to 17 mid sectors 6 and 7, 18 test.
   assign block_locked = (pulse_block < 5'h10) ?
                            low_protect[pulse_block[3:0]] :
                         (pulse_block < 5'h12) ?
                            mid_protect[pulse_block[0]] :
                         (pulse_block == 5'h12) ? test_shadow_protect :
                         1'b1; // [R15]
   assign pulse_grant = pulse_req && !block_locked; // [R12]
   assign pulse_refused = pulse_req && block_locked; // [R12]

   assign fetch_hit = fetch_during_write && !op_done;
   assign cpu_stall = saww_enable && !saww_abort && fetch_hit; // [R3]

   always @* begin
      case (LOW_SECT)
         `FLBL_LAS_2X128: low_count = 4'h2;
         `FLBL_LAS_MIX6: low_count = 4'h6;
         `FLBL_LAS_4X16: low_count = 4'h4;
         `FLBL_LAS_MIX8: low_count = 4'h8;
         default: low_count = 4'h0;
      endcase
   end
   assign low_sector_count = low_count; // [R1]
   assign low_sect_reserved = (LOW_SECT == 3'h3) || (LOW_SECT == 3'h4) ||
                              (LOW_SECT == 3'h5); // [R1]
   assign mid_sect_reserved = MID_SECT[0]; // [R1]

   assign erase_select = erase_sel;
   assign program_select = program_sel;
   assign high_voltage_enable = hv_enable;
   assign erase_suspend = erase_susp;

   // Command bits: one written change is applied per access, picked by level.
   always @* begin
      next_erase_sel = erase_sel;
      next_program_sel = program_sel;
      next_hv_enable = hv_enable;
      next_erase_susp = erase_susp;
      next_op_done = op_done;
      next_peg = operation_good_flag;
      next_rwe = read_while_write_error;
      next_saww_event = 1'b0;
      abort_now = 1'b0;
      chg[0] = reg_wdata[`FLBL_ERS] ^ erase_sel;
      chg[1] = reg_wdata[`FLBL_PGM] ^ program_sel;
      chg[2] = reg_wdata[`FLBL_EHV] ^ hv_enable;
      chg[3] = reg_wdata[`FLBL_ERASE_SUSPEND] ^ erase_susp;
      if (hv_seq_end && !op_done) begin
         next_op_done = 1'b1; // [R18]
         next_peg = !hv_seq_fail;
      end
      if (ctrl_wr) begin
         if (chg[0]) begin // [R2]
            if (!erase_sel && !program_sel)
               next_erase_sel = 1'b1;
            else if (erase_sel && !erase_susp && !hv_enable && op_done)
               next_erase_sel = 1'b0;
         end else if (chg[1]) begin // [R2]
            if (!program_sel && !erase_sel)
               next_program_sel = 1'b1;
            else if (program_sel && !hv_enable && op_done)
               next_program_sel = 1'b0;
         end else if (chg[2]) begin // [R2]
            if (!hv_enable && (erase_sel || program_sel) && !erase_susp) begin
               next_hv_enable = 1'b1;
               next_op_done = 1'b0;
            end else if (hv_enable && !(erase_susp && !op_done)) begin
               next_hv_enable = 1'b0;
               if (!op_done && !erase_susp)
                  abort_now = 1'b1;
            end
         end else if (chg[3]) begin // [R2]
            if (!erase_susp && erase_sel && hv_enable && !program_sel) begin
               next_erase_susp = 1'b1;
               next_op_done = 1'b1;
            end else if (erase_susp && op_done && hv_enable && !program_sel) begin
               next_erase_susp = 1'b0;
               next_op_done = 1'b0;
            end
         end
      end
      if (fetch_hit && saww_enable) begin
         next_saww_event = event_enable; // [R3]
         if (saww_abort) begin
            abort_now = 1'b1; // [R3]
         end else begin
            next_peg = 1'b1; // [R3]
         end
      end
      if (abort_now) begin
         next_hv_enable = 1'b0;
         next_op_done = 1'b1;
         next_peg = 1'b0;
      end
      // Error flag clears on a one; a new error in the same cycle still wins.
      if (ctrl_wr && reg_wdata[`FLBL_RWE])
         next_rwe = 1'b0; // [R19]
      if (fetch_hit && !saww_enable)
         next_rwe = 1'b1; // [R19]
   end

   always @(posedge clock) begin
      if (sys_rst) begin
         erase_sel <= 1'b0;
         program_sel <= 1'b0;
         hv_enable <= 1'b0;
         erase_susp <= 1'b0;
         prog_susp <= 1'b0;
         op_done <= 1'b1;
         operation_good_flag <= 1'b1;
         read_while_write_error <= 1'b0;
         saww_enable <= 1'b0;
         saww_abort <= 1'b0;
         event_enable <= 1'b0;
         saww_event <= 1'b0;
         interlock_seen <= 1'b0;
      end else begin
         erase_sel <= next_erase_sel;
         program_sel <= next_program_sel;
         hv_enable <= next_hv_enable;
         erase_susp <= next_erase_susp;
         op_done <= next_op_done;
         operation_good_flag <= next_peg;
         read_while_write_error <= next_rwe;
         saww_event <= next_saww_event;
         if (ctrl_wr) begin
            prog_susp <= reg_wdata[`FLBL_PSUS];
            saww_enable <= reg_wdata[`FLBL_SAWW_EN];
            saww_abort <= reg_wdata[`FLBL_SAWW_ABORT];
            event_enable <= reg_wdata[`FLBL_EVT_EN];
         end
         if (interlock_write)
            interlock_seen <= 1'b1;
         else if (next_op_done && !op_done)
            interlock_seen <= 1'b0; // [R18]
      end
   end

   // Reset parks the locks at all ones; the image is taken one edge later,
   // so no flip-flop copies a port value while reset is held.
   always @(posedge clock) begin
      if (sys_rst) begin
         lock_write_enable <= 1'b0;
         test_shadow_lock <= 1'b1; // [R16]
         mid_space_lock <= 2'h3;
         low_space_lock <= 16'hffff;
         image_load <= 1'b1;
      end else if (image_load) begin
         image_load <= 1'b0;
         test_shadow_lock <= image_low[`FLBL_TEST_SHADOW_LOCK]; // [R7]
         mid_space_lock <= image_low[`FLBL_MLK_LO+1:`FLBL_MLK_LO] |
                           ~MID_PRESENT; // [R14]
         low_space_lock <= image_low[15:0] | ~LOW_PRESENT; // [R13]
      end else begin
         if (password_hit && !lock_write_enable)
            lock_write_enable <= 1'b1; // [R9]
         if (lock_bits_wr) begin
            test_shadow_lock <= reg_wdata[`FLBL_TEST_SHADOW_LOCK]; // [R21]
            mid_space_lock <= (reg_wdata[`FLBL_MLK_LO+1:`FLBL_MLK_LO] &
                               MID_PRESENT) | ~MID_PRESENT; // [R14]
            low_space_lock <= (reg_wdata[15:0] & LOW_PRESENT) |
                              ~LOW_PRESENT; // [R15]
         end
      end
   end

   assign ctrl_value = {13'h0, event_enable, saww_abort, saww_enable,
                        read_while_write_error, 4'h0, op_done,
                        operation_good_flag, 4'h0, program_sel, prog_susp,
                        erase_sel, erase_susp, hv_enable};
   assign lock_value = {lock_write_enable, 10'h0, test_shadow_lock, 2'h0,
                        mid_space_lock, low_space_lock};
   assign sect_value = {28'h0, MID_SECT[0], LOW_SECT}; // [R1]

   // Read data stand only in the cycle after the strobe; unmapped reads zero.
   always @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0;
      end else if (reg_read) begin
         case (reg_addr)
            `FLBL_CTRL_OFS: reg_rdata <= ctrl_value;
            `FLBL_LOCK_OFS: reg_rdata <= lock_value;
            `FLBL_SECT_OFS: reg_rdata <= sect_value;
            default: reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end

endmodule

`default_nettype wire

// ==== verif/flbl_ctrl_asserts.sv ====
// Purpose: Port-level checks for the flash lock control block.
// Assumes: Bound to flbl_ctrl; one clock, synchronous reset.
// Notes: Lock state is only seen through the protect outputs.
`timescale 1ns/10ps
`default_nettype none
`include "flbl_defs.vh"
module flbl_ctrl_asserts #(
   parameter [2:0] LOW_SECT = 3'h7,
   parameter [15:0] LOW_PRESENT = 16'h003f
) (
   input wire clock,
   input wire sys_rst,
   input wire [`FLBL_AW-1:0] reg_addr,
   input wire reg_write,
   input wire reg_read,
   input wire [31:0] reg_rdata,
   input wire [15:0] secondary_low_lock,
   input wire [1:0] secondary_mid_lock,
   input wire secondary_test_shadow_lock,
   input wire hv_seq_end,
   input wire pulse_req,
   input wire [4:0] pulse_block,
   input wire pulse_grant,
   input wire pulse_refused,
   input wire [15:0] low_protect,
   input wire [1:0] mid_protect,
   input wire test_shadow_protect,
   input wire low_sect_reserved,
   input wire erase_select,
   input wire program_select,
   input wire erase_suspend,
   input wire lock_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   low_or_a: assert property
      ((low_protect & secondary_low_lock) == secondary_low_lock)
      else $error("secondary low lock not honoured");
   mid_or_a: assert property
      ((mid_protect & secondary_mid_lock) == secondary_mid_lock)
      else $error("secondary mid lock not honoured");
   shadow_or_a: assert property
      (secondary_test_shadow_lock |-> test_shadow_protect)
      else $error("secondary shadow lock not honoured");
   absent_locked_a: assert property
      ((low_protect | LOW_PRESENT) == 16'hffff)
      else $error("absent block unlocked");
   pulse_gate_a: assert property
      (pulse_req && pulse_block < 5'd16 |->
      pulse_grant == !low_protect[pulse_block[3:0]] &&
      pulse_refused == low_protect[pulse_block[3:0]])
      else $error("pulse decision wrong");
   beyond_refused_a: assert property
      (pulse_req && pulse_block > 5'd18 |-> pulse_refused && !pulse_grant)
      else $error("absent block pulse granted");
   busy_hold_a: assert property
      (lock_busy && reg_write && reg_addr == `FLBL_LOCK_OFS
      ##1 $stable(secondary_low_lock) |-> $stable(low_protect))
      else $error("lock write taken while busy");
   done_release_a: assert property
      (hv_seq_end && !erase_suspend |=> !lock_busy)
      else $error("lock blocking not released");
   prio_single_a: assert property
      ($rose(erase_select) |-> !$rose(program_select))
      else $error("two command bits applied");
   sect_code_a: assert property
      (low_sect_reserved == (LOW_SECT >= 3'h3 && LOW_SECT <= 3'h5))
      else $error("sector code reservation wrong");
   cover property (lock_busy && reg_write);
   cover property (pulse_req && pulse_refused);
   cover property (hv_seq_end);
endmodule
bind flbl_ctrl flbl_ctrl_asserts #(.LOW_SECT(LOW_SECT), .LOW_PRESENT(LOW_PRESENT)) i_chk (
   .clock, .sys_rst, .reg_addr, .reg_write, .reg_read, .reg_rdata,
   .secondary_low_lock, .secondary_mid_lock, .secondary_test_shadow_lock,
   .hv_seq_end, .pulse_req, .pulse_block, .pulse_grant, .pulse_refused,
   .low_protect, .mid_protect, .test_shadow_protect, .low_sect_reserved,
   .erase_select, .program_select, .erase_suspend, .lock_busy);
`default_nettype wire

// ==== verif/tb_flbl_ctrl.sv ====
// Purpose: Directed register-level test of the flash lock control block.
// Assumes: Default parameters; lock image held constant.
// Notes: Upper image half is nonzero to show it never reaches the locks.
`timescale 1ns/10ps
`default_nettype none
`include "flbl_defs.vh"
module tb_flbl_ctrl;
   localparam [63:0] IMG = 64'h5a5a_5a5a_0012_0005;
   localparam [31:0] LM = 32'h8013ffff;
   localparam [31:0] RL = (IMG[31:0] & 32'h0013ffff) |
                          {16'h0, ~`FLBL_LOW_PRESENT};
   localparam [31:0] SW = (32'h1 << `FLBL_SAWW_EN) | (32'h1 << `FLBL_EVT_EN);
   localparam [31:0] LOCK_WRITE_ENABLE = 32'h1 << `FLBL_LME;
   localparam [31:0] PROGRAM_SELECT = 32'h1 << `FLBL_PGM;
   localparam [31:0] HIGH_VOLTAGE_ENABLE = 32'h1 << `FLBL_EHV;
   localparam [31:0] READ_WHILE_WRITE_ERROR = 32'h1 << `FLBL_RWE;
   localparam [31:0] DN = 32'h1 << `FLBL_DONE;
   localparam [31:0] PG = 32'h1 << `FLBL_PEG;
   localparam [31:0] ERASE_SELECT = 32'h1 << `FLBL_ERS;
   localparam [31:0] CL = 32'h1;
   reg clock, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
   reg interlock_write = 1'b0, hv_seq_end = 1'b0, fetch_during_write = 1'b0;
   reg pulse_req = 1'b0;
   reg [4:0] pulse_block = 5'h0;
   reg [7:0] reg_addr = 8'h0;
   reg [31:0] reg_wdata = 32'h0;
   reg [15:0] secondary_low_lock = 16'h0;
   wire [31:0] reg_rdata;
   wire [15:0] low_protect;
   wire [3:0] low_sector_count;
   wire pulse_grant, pulse_refused, low_sect_reserved, mid_sect_reserved;
   wire erase_select, program_select, erase_suspend, lock_busy;
   wire cpu_stall, saww_event;
   integer mismatches = 0, checks_done = 0, cycles = 0;
   flbl_ctrl i_dut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .nonvolatile_lock_image(IMG), .secondary_low_lock,
      .secondary_mid_lock(2'h0), .secondary_test_shadow_lock(1'b0),
      .interlock_write, .hv_seq_end, .hv_seq_fail(1'b0), .fetch_during_write,
      .pulse_req, .pulse_block, .pulse_grant, .pulse_refused, .low_protect,
      .mid_protect(), .test_shadow_protect(), .cpu_stall, .saww_event,
      .low_sector_count, .low_sect_reserved, .mid_sect_reserved, .erase_select,
      .program_select, .high_voltage_enable(), .erase_suspend, .lock_busy);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task report_and_stop;
      begin
         $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // A hang in the handshake ends the run with a failure instead of looping.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches = mismatches + 1;
         report_and_stop;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clock) reg_write <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clock) reg_write <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp, input [31:0] m);
      begin
         @(posedge clock) reg_read <= 1'b1;
         reg_addr <= a;
         @(posedge clock) reg_read <= 1'b0;
         #1 chk(reg_rdata & m, exp & m);
      end
   endtask
   task probe(input [4:0] b, input g);
      begin
         @(posedge clock) pulse_block <= b;
         #1 chk({30'h0, pulse_grant, pulse_refused}, {30'h0, g, !g});
      end
   endtask
   task do_reset;
      begin
         @(posedge clock) sys_rst <= 1'b1;
         repeat (2) @(posedge clock);
         sys_rst <= 1'b0;
         repeat (2) @(posedge clock);
      end
   endtask
   initial begin
      do_reset;
      rd(`FLBL_LOCK_OFS, RL, LM);
      rd(`FLBL_SECT_OFS, 32'h7, 32'hf);
      chk({26'h0, low_sect_reserved, mid_sect_reserved,
         low_sector_count}, 32'h8);
      wr(`FLBL_LOCK_OFS, 32'h0);
      rd(`FLBL_LOCK_OFS, RL, LM);
      wr(`FLBL_LOCK_OFS, `FLBL_PASSWORD);
      rd(`FLBL_LOCK_OFS, RL | LOCK_WRITE_ENABLE, LM);
      wr(`FLBL_LOCK_OFS, 32'h0);
      rd(`FLBL_LOCK_OFS, 32'h8000ffc0, LM);
      secondary_low_lock <= 16'h0002;
      pulse_req <= 1'b1;
      probe(5'd1, 1'b0);
      probe(5'd0, 1'b1);
      probe(5'd16, 1'b1);
      probe(5'd18, 1'b1);
      probe(5'd19, 1'b0);
      chk({16'h0, low_protect}, 32'hffc2);
      pulse_req <= 1'b0;
      wr(`FLBL_CTRL_OFS, ERASE_SELECT | PROGRAM_SELECT);
      rd(`FLBL_CTRL_OFS, ERASE_SELECT, ERASE_SELECT | PROGRAM_SELECT);
      wr(`FLBL_CTRL_OFS, 32'h0);
      wr(`FLBL_CTRL_OFS, PROGRAM_SELECT);
      @(posedge clock) interlock_write <= 1'b1;
      @(posedge clock) interlock_write <= 1'b0;
      wr(`FLBL_CTRL_OFS, PROGRAM_SELECT | HIGH_VOLTAGE_ENABLE);
      rd(`FLBL_CTRL_OFS, 32'h0, DN);
      chk({31'h0, lock_busy}, CL);
      wr(`FLBL_LOCK_OFS, 32'h3f);
      @(posedge clock) fetch_during_write <= 1'b1;
      @(posedge clock) fetch_during_write <= 1'b0;
      rd(`FLBL_LOCK_OFS, 32'h8000ffc0, LM);
      @(posedge clock) hv_seq_end <= 1'b1;
      @(posedge clock) hv_seq_end <= 1'b0;
      rd(`FLBL_CTRL_OFS, DN | PG | READ_WHILE_WRITE_ERROR, DN | PG | READ_WHILE_WRITE_ERROR);
      wr(`FLBL_CTRL_OFS, PROGRAM_SELECT);
      rd(`FLBL_CTRL_OFS, READ_WHILE_WRITE_ERROR, READ_WHILE_WRITE_ERROR);
      wr(`FLBL_CTRL_OFS, READ_WHILE_WRITE_ERROR);
      rd(`FLBL_CTRL_OFS, 32'h0, READ_WHILE_WRITE_ERROR | PROGRAM_SELECT);
      wr(`FLBL_LOCK_OFS, 32'h3f);
      rd(`FLBL_LOCK_OFS, 32'h8000ffff, LM);
      wr(`FLBL_CTRL_OFS, PROGRAM_SELECT | SW);
      wr(`FLBL_CTRL_OFS, PROGRAM_SELECT | SW | HIGH_VOLTAGE_ENABLE);
      @(posedge clock) fetch_during_write <= 1'b1;
      #1 chk({31'h0, cpu_stall}, CL);
      @(posedge clock) fetch_during_write <= 1'b0;
      #1 chk({31'h0, saww_event}, CL);
      @(posedge clock) hv_seq_end <= 1'b1;
      @(posedge clock) hv_seq_end <= 1'b0;
      rd(`FLBL_CTRL_OFS, DN | PG, DN | PG | READ_WHILE_WRITE_ERROR);
      do_reset;
      rd(`FLBL_LOCK_OFS, RL, LM);
      report_and_stop;
   end
endmodule
`default_nettype wire
